// ### logic/ldir_pkg.sv
package ldir_pkg;

    // ----------------------------------------------------------------
    // configuration register indices
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_LDN      = 8'h07;
    localparam logic [7:0] IDX_BASE_LO  = 8'h26;
    localparam logic [7:0] IDX_BASE_HI  = 8'h27;
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_IRQ_SEL  = 8'h70;
    localparam logic [7:0] IDX_DMA_SEL  = 8'h74;

    // ----------------------------------------------------------------
    // logical device numbers and their storage slots
    // ----------------------------------------------------------------
    localparam logic [7:0] LDN_FLOPPY = 8'h00;
    localparam logic [7:0] LDN_PP     = 8'h03;
    localparam logic [7:0] LDN_UART1  = 8'h04;
    localparam logic [7:0] LDN_UART2  = 8'h05;
    localparam int         LDIR_NDEV  = 4;

    typedef enum logic [1:0] {
        SLOT_FLOPPY = 2'h0,
        SLOT_PP     = 2'h1,
        SLOT_UART1  = 2'h2,
        SLOT_UART2  = 2'h3
    } ldir_slot_type;

    // ----------------------------------------------------------------
    // configuration port placement
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG_BASE_STRAP_LO = 16'h002e;
    localparam logic [15:0] CFG_BASE_STRAP_HI = 16'h004e;
    localparam logic [15:0] CFG_BASE_ALIGN    = 16'hfffe;

    // ----------------------------------------------------------------
    // select register reset values and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] IRQ_SEL_RST_FLOPPY = 8'h06;
    localparam logic [7:0] IRQ_SEL_RST_OTHER  = 8'h00;
    localparam logic [7:0] DMA_SEL_RST_FLOPPY = 8'h02;
    localparam logic [7:0] DMA_SEL_RST_OTHER  = 8'h04;
    localparam logic [3:0] IRQ_NONE           = 4'h0;
    localparam logic [2:0] DMA_CH_FIRST       = 3'h1;
    localparam logic [2:0] DMA_CH_LAST        = 3'h3;
    localparam int         ACT_BIT            = 0;

    // ----------------------------------------------------------------
    // parallel port modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PP_MODE_STD    = 3'h0,
        PP_MODE_PS2    = 3'h1,
        PP_MODE_FIFO   = 3'h2,
        PP_MODE_ECP    = 3'h3,
        PP_MODE_EPP    = 3'h4,
        PP_MODE_RES    = 3'h5,
        PP_MODE_TEST   = 3'h6,
        PP_MODE_CONFIG = 3'h7
    } ldir_pp_mode_type;

endpackage

// ### logic/ldir_cfg_if.sv
// strobes from the port decoder into the configuration core
interface ldir_cfg_if;
    logic        idx_wr;
    logic        idx_rd;
    logic        dat_wr;
    logic        dat_rd;
    logic [7:0]  wdata;
    logic [15:0] base;

    modport dec  (input base, output idx_wr, idx_rd, dat_wr, dat_rd, wdata);
    modport core (output base, input idx_wr, idx_rd, dat_wr, dat_rd, wdata);
endinterface

// ### logic/ldir_cfg_decode.sv
module ldir_cfg_decode
    import ldir_pkg::*;
(
    input  wire logic [15:0] i_io_addr,
    input  wire logic        i_io_wr,
    input  wire logic        i_io_rd,
    input  wire logic [7:0]  i_io_wdata,
    ldir_cfg_if.dec          cfg
);

    // ----------------------------------------------------------------
    // index port at base, data port at base plus one
    // ----------------------------------------------------------------
    logic        hit_idx;
    logic        hit_dat;
    logic [15:0] dat_addr;

    assign dat_addr   = cfg.base | ~CFG_BASE_ALIGN;
    assign hit_idx    = (i_io_addr == cfg.base);
    assign hit_dat    = (i_io_addr == dat_addr);
    assign cfg.idx_wr = hit_idx & i_io_wr;
    assign cfg.idx_rd = hit_idx & i_io_rd;
    assign cfg.dat_wr = hit_dat & i_io_wr;
    assign cfg.dat_rd = hit_dat & i_io_rd;
    assign cfg.wdata  = i_io_wdata;

endmodule

// ### logic/ldir_core.sv
// Functional notes
// - port sits at one of two addresses picked by strap after power-up
// - global registers at indices 26h and 27h move the port base
// - interrupt select low nibble: zero none, else that line number
// - interrupt select resets to zero, floppy to six, also on soft reset
// - routed interrupts active high, parallel port enhanced modes active low
// - system management interrupt output is active low
// - interrupt only with non-zero select and local enable met
// - floppy interrupt and dma off while floppy dma gate is zero
// - floppy interrupt and dma off while floppy controller powered down
// - parallel irq needs irq gate except in fifo and test; in ecp mode also service mask clear
// - serial irq needs an enable bit and output-2 bit set
// - standard and epp modes: parallel irq off when irq gate zero
// - parallel dma follows dma gate; irq forced on in fifo and test
// - an interrupt line no device selects stays inactive
// - all fifteen line numbers are deliverable
// - dma select low three bits: one to three channels, four up none
// - dma select resets to two for floppy, four for others
// - dma active only with select one to three and local enable
// - ecp mode: parallel dma follows ecp dma gate
// - second serial port dma off when its dma enable is clear
// - a dma channel no device selects stays inactive
// - local disables suppress requests on top of activate bit
module ldir_core
    import ldir_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_soft_rst,
    input  wire logic        i_cfg_port_strap,
    input  wire logic [15:0] i_io_addr,
    input  wire logic        i_io_wr,
    input  wire logic        i_io_rd,
    input  wire logic [7:0]  i_io_wdata,
    input  wire logic        i_fdc_irq_req,
    input  wire logic        i_fdc_drq,
    input  wire logic        i_floppy_dma_gate,
    input  wire logic        i_floppy_powered_down,
    input  wire logic        i_pp_irq_req,
    input  wire logic        i_pp_drq,
    input  wire logic [2:0]  i_pp_mode,
    input  wire logic        i_pp_irq_gate,
    input  wire logic        i_ecp_service_irq_mask,
    input  wire logic        i_ecp_dma_gate,
    input  wire logic        i_uart1_irq_req,
    input  wire logic [3:0]  i_uart1_irq_enables,
    input  wire logic        i_uart1_irq_gate_output,
    input  wire logic        i_uart2_irq_req,
    input  wire logic [3:0]  i_uart2_irq_enables,
    input  wire logic        i_uart2_irq_gate_output,
    input  wire logic        i_uart2_drq,
    input  wire logic        i_uart2_dma_enable,
    input  wire logic        i_smi_req,
    input  wire logic        i_smi_enable,
    output logic [7:0]       o_io_rdata,
    output logic             o_io_rdata_vld,
    output logic [15:0]      o_cfg_base,
    output logic [15:1]      o_irq,
    output logic [3:1]       o_drq,
    output logic             o_system_mgmt_irq_n
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                 strap_s1;
        logic                 strap_s2;
        logic                 strap_v1;
        logic                 strap_v2;
        logic                 strap_done;
        logic [7:0]           index;
        logic [7:0]           ldn;
        logic [15:0]          base;
        logic [3:0]           act;
        logic [3:0][7:0]      irq_sel;
        logic [3:0][7:0]      dma_sel;
        logic [7:0]           rdata;
        logic                 rdata_vld;
        logic [15:1]          irq;
        logic [3:1]           drq;
        logic                 smi_n;
    } ldir_state_type;

    localparam logic [3:0][7:0] IRQ_SEL_RST = {IRQ_SEL_RST_OTHER, IRQ_SEL_RST_OTHER,
                                               IRQ_SEL_RST_OTHER, IRQ_SEL_RST_FLOPPY};
    localparam logic [3:0][7:0] DMA_SEL_RST = {DMA_SEL_RST_OTHER, DMA_SEL_RST_OTHER,
                                               DMA_SEL_RST_OTHER, DMA_SEL_RST_FLOPPY};

    localparam ldir_state_type ST_RST = '{
        strap_s1   : 1'b0,
        strap_s2   : 1'b0,
        strap_v1   : 1'b0,
        strap_v2   : 1'b0,
        strap_done : 1'b0,
        index      : 8'h00,
        ldn        : 8'h00,
        base       : CFG_BASE_STRAP_LO,
        act        : 4'h0,
        irq_sel    : IRQ_SEL_RST,
        dma_sel    : DMA_SEL_RST,
        rdata      : 8'h00,
        rdata_vld  : 1'b0,
        irq        : 15'h0000,
        drq        : 3'h0,
        smi_n      : 1'b1
    };

    ldir_state_type s_q;
    ldir_state_type s_d;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // device number to slot, with a valid flag on top
    function automatic logic [2:0] slot_of(input logic [7:0] ldn);
        logic [2:0] r;
        r = 3'h0;
        if (ldn == LDN_FLOPPY) begin
            r = {1'b1, SLOT_FLOPPY};
        end else if (ldn == LDN_PP) begin
            r = {1'b1, SLOT_PP};
        end else if (ldn == LDN_UART1) begin
            r = {1'b1, SLOT_UART1};
        end else if (ldn == LDN_UART2) begin
            r = {1'b1, SLOT_UART2};
        end
        return r;
    endfunction

    // select value to one line; zero lands on the dropped bit
    function automatic logic [15:1] line_of(input logic [3:0] sel);
        logic [15:0] v;
        v = 16'h0001 << sel;
        return v[15:1];
    endfunction

    // ----------------------------------------------------------------
    // port decoder
    // ----------------------------------------------------------------
    ldir_cfg_if cfg ();

    assign cfg.base = s_q.base;

    ldir_cfg_decode u_dec (
        .i_io_addr  (i_io_addr),
        .i_io_wr    (i_io_wr),
        .i_io_rd    (i_io_rd),
        .i_io_wdata (i_io_wdata),
        .cfg        (cfg)
    );

    // ----------------------------------------------------------------
    // local enable conditions per device
    // ----------------------------------------------------------------
    logic [3:0] irq_en;
    logic [3:0] dma_en;
    logic [3:0] irq_req;
    logic [3:0] dma_req;
    logic       pp_enh;
    logic [2:0] cur_slot;

    always_comb begin
        irq_en[SLOT_FLOPPY] = i_floppy_dma_gate & ~i_floppy_powered_down;
        dma_en[SLOT_FLOPPY] = i_floppy_dma_gate & ~i_floppy_powered_down;
        case (ldir_pp_mode_type'(i_pp_mode))
            PP_MODE_FIFO, PP_MODE_TEST: begin
                irq_en[SLOT_PP] = 1'b1;
            end
            PP_MODE_ECP: begin
                irq_en[SLOT_PP] = i_pp_irq_gate & ~i_ecp_service_irq_mask;
            end
            default: begin
                irq_en[SLOT_PP] = i_pp_irq_gate;
            end
        endcase
        dma_en[SLOT_PP]    = i_ecp_dma_gate;
        irq_en[SLOT_UART1] = (|i_uart1_irq_enables) & i_uart1_irq_gate_output;
        dma_en[SLOT_UART1] = 1'b0;
        irq_en[SLOT_UART2] = (|i_uart2_irq_enables) & i_uart2_irq_gate_output;
        dma_en[SLOT_UART2] = i_uart2_dma_enable;
        irq_req = {i_uart2_irq_req, i_uart1_irq_req, i_pp_irq_req, i_fdc_irq_req};
        dma_req = {i_uart2_drq, 1'b0, i_pp_drq, i_fdc_drq};
        pp_enh  = (i_pp_mode == PP_MODE_ECP) || (i_pp_mode == PP_MODE_EPP);
        cur_slot = slot_of(s_q.ldn);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [15:1] irq_nx;
        logic [3:1]  drq_nx;
        logic        lvl;
        logic [2:0]  ch;
        irq_nx = 15'h0000;
        drq_nx = 3'h0;
        lvl    = 1'b0;
        ch     = 3'h0;
        s_d    = s_q;

        // strap sync and one-shot capture after reset release
        s_d.strap_s1 = i_cfg_port_strap;
        s_d.strap_s2 = s_q.strap_s1;
        s_d.strap_v1 = 1'b1;
        s_d.strap_v2 = s_q.strap_v1;
        if (s_q.strap_v2 && !s_q.strap_done) begin
            s_d.base       = s_q.strap_s2 ? CFG_BASE_STRAP_HI : CFG_BASE_STRAP_LO;
            s_d.strap_done = 1'b1;
        end

        // host index and data port accesses
        if (cfg.idx_wr) begin
            s_d.index = cfg.wdata;
        end
        if (cfg.dat_wr) begin
            if (s_q.index == IDX_LDN) begin
                s_d.ldn = cfg.wdata;
            end else if (s_q.index == IDX_BASE_LO) begin
                s_d.base[7:0] = cfg.wdata & CFG_BASE_ALIGN[7:0];
            end else if (s_q.index == IDX_BASE_HI) begin
                s_d.base[15:8] = cfg.wdata;
            end else if (cur_slot[2] && s_q.index == IDX_ACTIVATE) begin
                s_d.act[cur_slot[1:0]] = cfg.wdata[ACT_BIT];
            end else if (cur_slot[2] && s_q.index == IDX_IRQ_SEL) begin
                s_d.irq_sel[cur_slot[1:0]] = cfg.wdata;
            end else if (cur_slot[2] && s_q.index == IDX_DMA_SEL) begin
                s_d.dma_sel[cur_slot[1:0]] = cfg.wdata;
            end
        end

        // soft reset restores the selects
        if (i_soft_rst) begin
            s_d.irq_sel = IRQ_SEL_RST;
            s_d.dma_sel = DMA_SEL_RST;
        end

        // read data
        s_d.rdata_vld = cfg.idx_rd | cfg.dat_rd;
        s_d.rdata     = 8'h00;
        if (cfg.idx_rd) begin
            s_d.rdata = s_q.index;
        end else if (cfg.dat_rd) begin
            if (s_q.index == IDX_LDN) begin
                s_d.rdata = s_q.ldn;
            end else if (s_q.index == IDX_BASE_LO) begin
                s_d.rdata = s_q.base[7:0];
            end else if (s_q.index == IDX_BASE_HI) begin
                s_d.rdata = s_q.base[15:8];
            end else if (cur_slot[2] && s_q.index == IDX_ACTIVATE) begin
                s_d.rdata = {7'h00, s_q.act[cur_slot[1:0]]};
            end else if (cur_slot[2] && s_q.index == IDX_IRQ_SEL) begin
                s_d.rdata = s_q.irq_sel[cur_slot[1:0]];
            end else if (cur_slot[2] && s_q.index == IDX_DMA_SEL) begin
                s_d.rdata = s_q.dma_sel[cur_slot[1:0]];
            end
        end

        // interrupt and dma routing per device
        for (int d = 0; d < LDIR_NDEV; d++) begin
            lvl = (d == int'(SLOT_PP) && pp_enh) ? ~irq_req[d] : irq_req[d];
            if (s_q.act[d] && irq_en[d] && lvl) begin
                irq_nx = irq_nx | line_of(s_q.irq_sel[d][3:0]);
            end
            ch = s_q.dma_sel[d][2:0];
            if (s_q.act[d] && dma_en[d] && dma_req[d] &&
                ch >= DMA_CH_FIRST && ch <= DMA_CH_LAST) begin
                drq_nx[ch] = 1'b1;
            end
        end
        s_d.irq   = irq_nx;
        s_d.drq   = drq_nx;
        s_d.smi_n = ~(i_smi_req & i_smi_enable);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign o_io_rdata          = s_q.rdata;
    assign o_io_rdata_vld      = s_q.rdata_vld;
    assign o_cfg_base          = s_q.base;
    assign o_irq               = s_q.irq;
    assign o_drq               = s_q.drq;
    assign o_system_mgmt_irq_n = s_q.smi_n;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_fdc_alone;
        s_q.act == 4'h1;
    endsequence

    sequence s_fdc_live(logic [3:0] k);
        s_fdc_alone ##0 irq_en[SLOT_FLOPPY] ##0 i_fdc_irq_req
            ##0 s_q.irq_sel[SLOT_FLOPPY][3:0] == k;
    endsequence

    property p_strap_base;
        $rose(s_q.strap_done) |->
            s_q.base == ($past(s_q.strap_s2) ? CFG_BASE_STRAP_HI : CFG_BASE_STRAP_LO);
    endproperty
    a_strap_base: assert property (p_strap_base)
        else $error("config base not taken from strap");

    property p_base_move;
        (cfg.dat_wr && s_q.index == IDX_BASE_HI && !cfg.idx_wr) |=>
            o_cfg_base[15:8] == $past(i_io_wdata) ##1 o_cfg_base[15:8] == $past(i_io_wdata, 2);
    endproperty
    a_base_move: assert property (p_base_move)
        else $error("config base high byte not moved");

    property p_irq_sel_soft;
        i_soft_rst |=> s_q.irq_sel[SLOT_FLOPPY] == IRQ_SEL_RST_FLOPPY
            && s_q.irq_sel[SLOT_UART2] == IRQ_SEL_RST_OTHER;
    endproperty
    a_irq_sel_soft: assert property (p_irq_sel_soft)
        else $error("interrupt select not restored by soft reset");

    property p_dma_sel_soft;
        i_soft_rst |=> s_q.dma_sel[SLOT_FLOPPY] == DMA_SEL_RST_FLOPPY
            && s_q.dma_sel[SLOT_PP] == DMA_SEL_RST_OTHER;
    endproperty
    a_dma_sel_soft: assert property (p_dma_sel_soft)
        else $error("dma select not restored by soft reset");

    property p_smi_low;
        (i_smi_req && i_smi_enable) |=> !o_system_mgmt_irq_n;
    endproperty
    a_smi_low: assert property (p_smi_low)
        else $error("management interrupt not driven low");

    property p_fdc_line(logic [3:0] k);
        s_fdc_live(k) |=> o_irq == line_of($past(k));
    endproperty
    a_fdc_line: assert property (p_fdc_line(s_q.irq_sel[SLOT_FLOPPY][3:0]))
        else $error("floppy request on wrong line");

    property p_fdc_off;
        (s_fdc_alone ##0 (!i_floppy_dma_gate || i_floppy_powered_down)) |=>
            o_irq == 15'h0000 && o_drq == 3'h0;
    endproperty
    a_fdc_off: assert property (p_fdc_off)
        else $error("floppy request passed while gated");

    property p_uart_off;
        (s_q.act == 4'hc && !i_uart1_irq_gate_output && !i_uart2_irq_gate_output) |=>
            o_irq == 15'h0000;
    endproperty
    a_uart_off: assert property (p_uart_off)
        else $error("serial interrupt passed with output-2 clear");

    property p_dma_none;
        (s_fdc_alone ##0 s_q.dma_sel[SLOT_FLOPPY][2] == 1'b1) |=> o_drq == 3'h0;
    endproperty
    a_dma_none: assert property (p_dma_none)
        else $error("dma driven with no channel selected");

    property p_pp_forced;
        (s_q.act == 4'h2 && i_pp_mode == PP_MODE_FIFO && i_pp_irq_req
            && s_q.irq_sel[SLOT_PP][3:0] != IRQ_NONE) |=>
            o_irq == line_of($past(s_q.irq_sel[SLOT_PP][3:0]));
    endproperty
    a_pp_forced: assert property (p_pp_forced)
        else $error("parallel interrupt not forced on in fifo mode");

endmodule

// ### bench/ldir_host_model.sv
// edge-sensitive host side: counts cycles with a rising request edge on any line
module ldir_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [15:1] i_irq,
    output logic [7:0]       o_edge_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:1] prev_q;
    // a held line counts once; only a new high edge is a request
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_q     <= '0;
            o_edge_cnt <= 8'h00;
        end else begin
            prev_q <= i_irq;
            if (|(i_irq & ~prev_q)) begin
                o_edge_cnt <= o_edge_cnt + 8'h01;
            end
        end
    end
endmodule

// ### bench/ldir_core_tb_top.sv
module ldir_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ldir_pkg::*;
    logic i_clk, i_rst_n, i_soft_rst, i_cfg_port_strap, i_io_wr, i_io_rd, i_fdc_irq_req;
    logic i_fdc_drq, i_floppy_dma_gate, i_floppy_powered_down, i_pp_irq_req, i_pp_drq;
    logic i_pp_irq_gate, i_ecp_service_irq_mask, i_ecp_dma_gate, u_req, u_gate;
    logic i_uart2_drq, i_uart2_dma_enable, i_smi_req, i_smi_enable;
    logic o_io_rdata_vld, o_system_mgmt_irq_n;
    logic [15:0] i_io_addr, o_cfg_base, base;
    logic [7:0]  i_io_wdata, o_io_rdata, edge_cnt;
    logic [3:0]  u_en;
    logic [2:0]  i_pp_mode;
    logic [15:1] o_irq;
    logic [3:1]  o_drq;
    int          n_fail = 0;
    int          checks_done = 0;

    ldir_core u_ldir_core (.*, .i_uart1_irq_req(u_req), .i_uart1_irq_enables(u_en),
        .i_uart1_irq_gate_output(u_gate), .i_uart2_irq_req(u_req),
        .i_uart2_irq_enables(u_en), .i_uart2_irq_gate_output(u_gate));
    ldir_host_model u_ldir_host_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_irq(o_irq),
        .o_edge_cnt(edge_cnt));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one strobe cycle, released at the edge that takes it
    task automatic io(input logic [15:0] a, input logic [7:0] d, input logic rd);
        @(posedge i_clk);
        i_io_addr  <= a;
        i_io_wdata <= d;
        i_io_wr    <= !rd;
        i_io_rd    <= rd;
        @(posedge i_clk);
        i_io_wr <= 1'b0;
        i_io_rd <= 1'b0;
        #1;
    endtask
    task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
        io(base, idx, 1'b0);
        io(base + 16'h0001, d, 1'b0);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        io(base, idx, 1'b0);
        io(base + 16'h0001, 8'h00, 1'b1);
        chk({o_io_rdata_vld, 7'h00, o_io_rdata}, {1'b1, 7'h00, exp}, what);
    endtask
    task automatic settle;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic dev(input logic [7:0] ldn, input logic [7:0] irq, input logic [7:0] dma);
        cfg(IDX_LDN, ldn);
        cfg(IDX_ACTIVATE, 8'h01);
        cfg(IDX_IRQ_SEL, irq);
        cfg(IDX_DMA_SEL, dma);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk(o_cfg_base, 16'h002e, "strap base");
        chk({o_irq, o_system_mgmt_irq_n}, 16'h0001, "idle lines");
        chk({13'h0, o_drq}, 16'h0000, "idle dma");
        cfg(IDX_LDN, 8'h00);
        rd_chk(IDX_IRQ_SEL, 8'h06, "fdc irq rst");
        rd_chk(IDX_DMA_SEL, 8'h02, "fdc dma rst");
        cfg(IDX_LDN, 8'h03);
        rd_chk(IDX_IRQ_SEL, 8'h00, "pp irq rst");
        rd_chk(IDX_DMA_SEL, 8'h04, "pp dma rst");
        $display("test reset done");
    endtask
    task automatic t_floppy;
        dev(LDN_FLOPPY, 8'h06, 8'h02);
        @(posedge i_clk);
        i_fdc_irq_req     <= 1'b1;
        i_fdc_drq         <= 1'b1;
        i_floppy_dma_gate <= 1'b1;
        settle;
        chk({o_irq, o_drq[2]}, 16'h0041, "fdc on");
        chk(edge_cnt, 16'h0001, "host edge");
        @(posedge i_clk);
        i_floppy_dma_gate <= 1'b0;
        settle;
        chk({o_irq, o_drq[2]}, 16'h0000, "dma gate off");
        @(posedge i_clk);
        i_floppy_dma_gate     <= 1'b1;
        i_floppy_powered_down <= 1'b1;
        settle;
        chk({o_irq, o_drq[2]}, 16'h0000, "powered down");
        @(posedge i_clk);
        i_floppy_powered_down <= 1'b0;
        // sweep all sixteen interrupt selects, then all eight dma selects
        for (int n = 0; n < 16; n++) begin
            cfg(IDX_IRQ_SEL, 8'(n));
            settle;
            chk({o_irq, 1'b0}, (n == 0) ? 16'h0000 : 16'h0001 << n, "line");
        end
        for (int c = 0; c < 8; c++) begin
            cfg(IDX_DMA_SEL, 8'(c));
            settle;
            chk({13'h0, o_drq}, (c >= 1 && c <= 3) ? 16'h1 << (c - 1) : 0, "ch");
        end
        @(posedge i_clk);
        i_fdc_irq_req <= 1'b0;
        i_fdc_drq     <= 1'b0;
        cfg(IDX_ACTIVATE, 8'h00);
        $display("test floppy done");
    endtask
    task automatic t_uart;
        dev(LDN_UART1, 8'h04, 8'h04);
        dev(LDN_UART2, 8'h03, 8'h01);
        @(posedge i_clk);
        u_req       <= 1'b1;
        u_gate      <= 1'b1;
        i_uart2_drq <= 1'b1;
        settle;
        chk({o_irq[4:3], o_drq[1]}, 16'h0000, "no enables");
        @(posedge i_clk);
        u_en               <= 4'h8;
        i_uart2_dma_enable <= 1'b1;
        settle;
        chk({o_irq[4:3], o_drq[1]}, 16'h0007, "uart on");
        @(posedge i_clk);
        u_gate <= 1'b0;
        settle;
        chk({o_irq[4:3], o_drq[1]}, 16'h0001, "uart_irq_gate_output off");
        cfg(IDX_ACTIVATE, 8'h00);
        cfg(IDX_LDN, LDN_UART1);
        cfg(IDX_ACTIVATE, 8'h00);
        $display("test uart done");
    endtask
    task automatic t_pp;
        dev(LDN_PP, 8'h07, 8'h03);
        @(posedge i_clk);
        i_pp_irq_req <= 1'b1;
        i_pp_drq     <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            @(posedge i_clk);
            i_pp_mode      <= 3'(m);
            i_ecp_dma_gate <= m[0];
            settle;
            chk({o_irq[7], o_drq[3]}, {m == 2 || m == 6, m[0]}, "pp mode");
        end
        @(posedge i_clk);
        i_pp_mode     <= PP_MODE_STD;
        i_pp_irq_gate <= 1'b1;
        settle;
        chk(o_irq[7], 16'h0001, "pp gate");
        // enhanced modes show a pending request as a low line
        @(posedge i_clk);
        i_pp_mode <= PP_MODE_ECP;
        settle;
        chk(o_irq[7], 16'h0000, "ecp req low");
        @(posedge i_clk);
        i_pp_irq_req           <= 1'b0;
        i_ecp_service_irq_mask <= 1'b1;
        settle;
        chk(o_irq[7], 16'h0000, "ecp masked");
        @(posedge i_clk);
        i_ecp_service_irq_mask <= 1'b0;
        settle;
        chk(o_irq[7], 16'h0001, "ecp idle high");
        $display("test pp done");
    endtask
    task automatic t_misc;
        cfg(IDX_BASE_LO, 8'h71);
        base = 16'h0070;
        chk(o_cfg_base, 16'h0070, "moved base");
        cfg(IDX_BASE_HI, 8'h01);
        base = 16'h0170;
        chk(o_cfg_base, 16'h0170, "moved high");
        cfg(IDX_LDN, 8'h03);
        rd_chk(IDX_DMA_SEL, 8'h03, "new port");
        @(posedge i_clk);
        i_soft_rst <= 1'b1;
        @(posedge i_clk);
        i_soft_rst <= 1'b0;
        rd_chk(IDX_IRQ_SEL, 8'h00, "soft pp");
        rd_chk(IDX_DMA_SEL, 8'h04, "soft pp dma");
        cfg(IDX_LDN, 8'h00);
        rd_chk(IDX_IRQ_SEL, 8'h06, "soft fdc");
        rd_chk(IDX_DMA_SEL, 8'h02, "soft fdc dma");
        @(posedge i_clk);
        i_smi_enable <= 1'b1;
        i_smi_req    <= 1'b1;
        settle;
        chk(o_system_mgmt_irq_n, 16'h0000, "smi low");
        // second power-up with the strap high
        @(posedge i_clk);
        i_cfg_port_strap <= 1'b1;
        i_rst_n          <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (5) @(posedge i_clk);
        #1;
        chk(o_cfg_base, 16'h004e, "strap high base");
        base = 16'h004e;
        cfg(IDX_LDN, 8'h05);
        rd_chk(IDX_DMA_SEL, 8'h04, "uart2 dma rst");
        $display("test misc done");
    endtask

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // watchdog for a hung run
    initial begin
        #200us;
        n_fail++;
        conclude;
    end
    initial begin
        {i_rst_n, i_soft_rst, i_cfg_port_strap, i_io_wr, i_io_rd, i_fdc_irq_req} = '0;
        {i_fdc_drq, i_floppy_dma_gate, i_floppy_powered_down, i_pp_irq_req, i_pp_drq} = '0;
        {i_pp_irq_gate, i_ecp_service_irq_mask, i_ecp_dma_gate, u_req, u_gate} = '0;
        {i_uart2_drq, i_uart2_dma_enable, i_smi_req, i_smi_enable, u_en, i_pp_mode} = '0;
        {i_io_addr, i_io_wdata} = '0;
        base = 16'h002e;
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (5) @(posedge i_clk);
        #1;
        t_reset;
        t_floppy;
        t_uart;
        t_pp;
        t_misc;
        conclude;
    end
endmodule
